/* File: cca_defs.svh */
`ifndef CCA_DEFS_SVH
`define CCA_DEFS_SVH

// **********************************************************************
// Register map
// **********************************************************************
`define CCA_REG_W          8
`define CCA_ADDR_ID        8'h00
`define CCA_ADDR_RCR       8'h01
`define CCA_ADDR_MCR       8'h02
`define CCA_ADDR_ACR       8'h03

// **********************************************************************
// Reset values and field positions
// **********************************************************************
`define CCA_RCR_RST        8'h18
`define CCA_RCR_DIR_BIT    5
`define CCA_MCR_RST        8'h34
`define CCA_MCR_STDBY_BIT  7
`define CCA_MCR_VCO_BIT    6
`define CCA_MCR_SER_BIT    3
`define CCA_ACR_RST        8'h2A

// **********************************************************************
// Auxiliary generator
// **********************************************************************
`define CCA_MODE_STATIC    3'h0
`define CCA_MODE_HF        3'h1
`define CCA_MODE_LF_FIRST  3'h2
`define CCA_HF_PRE_HALF    18'h00004
`define CCA_LF_PRE_BASE    18'h01000
`define CCA_LF_DIV_BASE    6'h20
`define CCA_HF_DIV_ZERO    6'h20

`endif

/* File: cca_pkg.sv */
`include "cca_defs.svh"

package cca_pkg;

    typedef struct packed {
        logic [`CCA_REG_W-1:0] reference_clock_config;
        logic [`CCA_REG_W-1:0] master_clock_config;
        logic [`CCA_REG_W-1:0] auxiliary_clock_config;
        logic [`CCA_REG_W-1:0] rdData;
        logic                  dirSync1;
        logic                  dirSync2;
        logic                  stbySync1;
        logic                  stbySync2;
        logic                  auxOut;
    } cca_regs_t;

endpackage : cca_pkg

/* File: cca_aux_divider.sv */
`timescale 1ns/1ps
`include "cca_defs.svh"

module cca_aux_divider #(
    parameter int PRE_W = 18,                  // Prescaler counter width
    parameter int DIV_W = 6                    // Divider counter width
) (
    input  wire logic             ref_clk,     // Block clock
    input  wire logic             rst,         // Synchronous reset
    input  wire logic             restart,     // Clear counts, output low
    input  wire logic             tick,        // One VCO period elapsed
    input  wire logic [PRE_W-1:0] preHalf,     // Ticks per divider step
    input  wire logic [DIV_W-1:0] divLimit,    // Steps per half period
    output logic                  divOut       // Square wave
);

    typedef struct packed {
        logic [PRE_W-1:0] pre;
        logic [DIV_W-1:0] div;
        logic             out;
    } cca_div_state_t;

    cca_div_state_t q;
    cca_div_state_t d;

    // **********************************************************************
    // Counters
    // **********************************************************************
    // Toggling after a full prescale x divide count gives a 50% duty cycle
    always_comb begin
        d = q;
        if (rst || restart) begin
            d = '0;
        end else if (tick) begin
            if (q.pre == preHalf - PRE_W'(1)) begin
                d.pre = '0;
                if (q.div == divLimit - DIV_W'(1)) begin
                    d.div = '0;
                    d.out = ~q.out;
                end else begin
                    d.div = q.div + DIV_W'(1);
                end
            end else begin
                d.pre = q.pre + PRE_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        q <= d;
    end

    assign divOut = q.out;

endmodule : cca_aux_divider

/* File: cca_clock_config.sv */
`timescale 1ns/1ps
`include "cca_defs.svh"

// Notes on behaviour
// - Signed quantities are two's complement; these fields are unsigned.
// - Address 00 reads a fixed 8-bit release code and ignores writes.
// - Direct select bit resets to the strap pin level (18 or 38).
// - Standby bit 7 of master register resets to the pin (34 or B4).
// - Master register bit 6 high powers the VCO down, low keeps it on.
// - Master register bit 3 picks master clock or VCO/6 serial ceiling.
// - Master register bits 2:0 pick the VCO to master clock divider.
// - Aux prescaler 7:5, divider 4:0; code 000 drives bit 0 statically.
// - Code 001 gives the VCO divided by eight and by the divider.
// - Codes 010-111 divide by 8192 x 2^(prescaler - 2) x (32 + divider).

module cca_clock_config #(
    parameter logic [7:0] ID_VALUE = 8'h5C,       // Arbitrary release code
    parameter int         PRE_W    = 18,          // Prescaler counter width
    parameter int         DIV_W    = 6            // Divider counter width
) (
    input  wire logic       ref_clk,              // 200 MHz clock
    input  wire logic       rst,                  // Synchronous reset
    input  wire logic [7:0] regAddr,              // Register address
    input  wire logic       regWrEn,              // Write strobe
    input  wire logic [7:0] regWrData,            // Write data
    output logic      [7:0] regRdData,            // Read data, next cycle
    input  wire logic       vcoPulse,             // One pulse per VCO period
    input  wire logic       directClockStrapPin,  // Strap, asynchronous
    input  wire logic       standbyPin,           // Strap, asynchronous
    output logic      [1:0] refFactorK,           // Reference factor K
    output logic            directClockSelect,    // Direct clock select
    output logic      [4:0] refFactorM,           // Reference factor M
    output logic            standbyMode,          // Standby
    output logic            vcoPowerDown,         // VCO switched off
    output logic            serialClockLimitSelect, // Serial ceiling select
    output logic      [2:0] masterClockDivider,   // VCO to master divider
    output logic            auxClkOut             // Auxiliary clock output
);

    cca_pkg::cca_regs_t q;
    cca_pkg::cca_regs_t d;

    logic [2:0]       auxMode;
    logic [4:0]       auxDiv;
    logic [PRE_W-1:0] preHalf;
    logic [DIV_W-1:0] divLimit;
    logic             acrWrite;
    logic             divRestart;
    logic             divTick;
    logic             divOut;

    // **********************************************************************
    // Auxiliary generator setup
    // **********************************************************************
    assign auxMode  = q.auxiliary_clock_config[7:5];
    assign auxDiv   = q.auxiliary_clock_config[4:0];
    assign acrWrite = regWrEn && (regAddr == `CCA_ADDR_ACR);

    // A divider of zero would wrap the count, so HF treats it as 32
    always_comb begin
        if (auxMode == `CCA_MODE_HF) begin
            preHalf  = PRE_W'(`CCA_HF_PRE_HALF);
            divLimit = (auxDiv == 5'h00) ? DIV_W'(`CCA_HF_DIV_ZERO)
                                         : DIV_W'(auxDiv);
        end else begin
            preHalf  = PRE_W'(`CCA_LF_PRE_BASE)
                       << (auxMode - `CCA_MODE_LF_FIRST);
            divLimit = DIV_W'(`CCA_LF_DIV_BASE) + DIV_W'(auxDiv);
        end
    end

    // Counting stops while the VCO is off; the output then holds its level
    assign divTick    = vcoPulse && !q.master_clock_config[`CCA_MCR_VCO_BIT];
    assign divRestart = acrWrite;

    cca_aux_divider #(
        .PRE_W (PRE_W),
        .DIV_W (DIV_W)
    ) u_aux_divider (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .restart  (divRestart),
        .tick     (divTick),
        .preHalf  (preHalf),
        .divLimit (divLimit),
        .divOut   (divOut)
    );

    // **********************************************************************
    // Registers, strap capture and read-back
    // **********************************************************************
    always_comb begin
        d = q;
        // Straps pass two flops; only the second one is captured
        d.dirSync1  = directClockStrapPin;
        d.dirSync2  = q.dirSync1;
        d.stbySync1 = standbyPin;
        d.stbySync2 = q.stbySync1;
        if (rst) begin
            d.reference_clock_config = `CCA_RCR_RST;
            d.reference_clock_config[`CCA_RCR_DIR_BIT] = q.dirSync2;
            d.master_clock_config = `CCA_MCR_RST;
            d.master_clock_config[`CCA_MCR_STDBY_BIT] = q.stbySync2;
            d.auxiliary_clock_config = `CCA_ACR_RST;
            d.rdData = '0;
            d.auxOut = 1'b0;
        end else begin
            if (regWrEn) begin
                case (regAddr)
                    `CCA_ADDR_RCR: d.reference_clock_config = regWrData;
                    `CCA_ADDR_MCR: d.master_clock_config = regWrData;
                    `CCA_ADDR_ACR: d.auxiliary_clock_config = regWrData;
                    default: ;
                endcase
            end
            // Fields are unsigned, so read-back needs no sign handling
            case (regAddr)
                `CCA_ADDR_ID:  d.rdData = ID_VALUE;
                `CCA_ADDR_RCR: d.rdData = q.reference_clock_config;
                `CCA_ADDR_MCR: d.rdData = q.master_clock_config;
                `CCA_ADDR_ACR: d.rdData = q.auxiliary_clock_config;
                default:       d.rdData = '0;
            endcase
            if (auxMode == `CCA_MODE_STATIC) begin
                d.auxOut = q.auxiliary_clock_config[0];
            end else begin
                d.auxOut = divOut;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        q <= d;
    end

    // **********************************************************************
    // Outputs
    // **********************************************************************
    assign regRdData              = q.rdData;
    assign refFactorK             = q.reference_clock_config[7:6];
    assign directClockSelect      = q.reference_clock_config[`CCA_RCR_DIR_BIT];
    assign refFactorM             = q.reference_clock_config[4:0];
    assign standbyMode            = q.master_clock_config[`CCA_MCR_STDBY_BIT];
    assign vcoPowerDown           = q.master_clock_config[`CCA_MCR_VCO_BIT];
    assign serialClockLimitSelect = q.master_clock_config[`CCA_MCR_SER_BIT];
    assign masterClockDivider     = q.master_clock_config[2:0];
    assign auxClkOut              = q.auxOut;

    // **********************************************************************
    // Checks
    // **********************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    chk_id_readonly: assert property (
        (regAddr == `CCA_ADDR_ID) |=> (regRdData == ID_VALUE))
        else $error("release code read back wrong");

    chk_unmapped_zero: assert property (
        (regAddr > `CCA_ADDR_ACR) |=> (regRdData == 8'h00))
        else $error("unmapped address read nonzero");

    chk_dir_strap: assert property (
        $fell(rst) |-> (directClockSelect == $past(q.dirSync2))
                       && (q.reference_clock_config[4:0] == 5'(`CCA_RCR_RST)))
        else $error("direct select did not follow strap");

    chk_stby_strap: assert property (
        $fell(rst) |-> (standbyMode == $past(q.stbySync2))
                       && (q.master_clock_config[6:0] == 7'(`CCA_MCR_RST)))
        else $error("standby did not follow pin");

    chk_acr_reset: assert property (
        $fell(rst) |-> (q.auxiliary_clock_config == `CCA_ACR_RST))
        else $error("auxiliary register reset wrong");

    chk_vco_power: assert property (
        (regWrEn && regAddr == `CCA_ADDR_MCR)
        |=> (vcoPowerDown == $past(regWrData[`CCA_MCR_VCO_BIT]))
            && (vcoPowerDown ? !divTick : (divTick == vcoPulse)))
        else $error("VCO power bit wrong");

    chk_serial_clock_limit_select_sel: assert property (
        (regWrEn && regAddr == `CCA_ADDR_MCR)
        |=> (serialClockLimitSelect == $past(regWrData[`CCA_MCR_SER_BIT])))
        else $error("serial ceiling select wrong");

    chk_mclk_div: assert property (
        (regWrEn && regAddr == `CCA_ADDR_MCR)
        |=> (masterClockDivider == $past(regWrData[2:0])))
        else $error("master divider wrong");

    chk_aux_static: assert property (
        (auxMode == `CCA_MODE_STATIC) |=> (auxClkOut == $past(q.auxiliary_clock_config[0])))
        else $error("static auxiliary level wrong");

    chk_hf_setup: assert property (
        (auxMode == `CCA_MODE_HF && auxDiv != 5'h00)
        |-> (preHalf == PRE_W'(4)) && (divLimit == DIV_W'(auxDiv)))
        else $error("HF divide setup wrong");

    chk_lf_setup: assert property (
        (auxMode == 3'h4)
        |-> (preHalf == PRE_W'(16384)) && (divLimit == DIV_W'(auxDiv) + 6'd32))
        else $error("LF divide setup wrong");

    chk_write_restart: assert property (
        (acrWrite && regWrData[7:5] != `CCA_MODE_STATIC)
        |=> ##1 !auxClkOut)
        else $error("auxiliary write did not restart");

    cov_static_mode: cover property (
        (auxMode == `CCA_MODE_STATIC) ##1 auxClkOut);

    cov_hf_toggle: cover property (
        (auxMode == `CCA_MODE_HF) && $rose(auxClkOut));

    cov_lf_toggle: cover property (
        (auxMode >= `CCA_MODE_LF_FIRST) && $rose(auxClkOut));

    cov_strap_high: cover property (
        $fell(rst) && directClockSelect && standbyMode);

endmodule : cca_clock_config

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "cca_defs.svh"

module tb_top;
    typedef struct {
        int         due;
        int         sel;
        logic [7:0] exp;
        logic [7:0] msk;
    } cca_note_t;

    localparam logic [7:0] TB_ID = 8'h3D;  // Arbitrary release code

    logic       ref_clk = 1'h0;
    logic       rst;
    logic [7:0] regAddr, regWrData, regRdData;
    logic       regWrEn, vcoPulse, directClockStrapPin, standbyPin;
    logic [1:0] refFactorK;
    logic [4:0] refFactorM;
    logic [2:0] masterClockDivider;
    logic       directClockSelect, standbyMode, vcoPowerDown;
    logic       serialClockLimitSelect, auxClkOut;
    int         cyc = 0;
    int         mismatches = 0;
    int         comparisons = 0;
    cca_note_t  notes[$];
    cca_note_t  n;

    cca_clock_config #(.ID_VALUE(TB_ID)) cca_clock_config_i (
        .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
        .vcoPulse(vcoPulse), .directClockStrapPin(directClockStrapPin),
        .standbyPin(standbyPin), .refFactorK(refFactorK),
        .directClockSelect(directClockSelect), .refFactorM(refFactorM),
        .standbyMode(standbyMode), .vcoPowerDown(vcoPowerDown),
        .serialClockLimitSelect(serialClockLimitSelect),
        .masterClockDivider(masterClockDivider), .auxClkOut(auxClkOut));

    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    // ****************************************************************
    // Observation
    // ****************************************************************
    function automatic logic [7:0] obs(input int s);
        case (s)
            0: obs = regRdData;
            1: obs = {refFactorK, directClockSelect, refFactorM};
            2: obs = {standbyMode, vcoPowerDown, 2'h0,
                      serialClockLimitSelect, masterClockDivider};
            default: obs = {7'h00, auxClkOut};
        endcase
    endfunction : obs

    // Notes are due in order, so the oldest one gates the rest
    always @(posedge ref_clk) begin
        #2;
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            n = notes.pop_front();
            comparisons++;
            if (((obs(n.sel) ^ n.exp) & n.msk) !== 8'h00) begin
                mismatches++;
                $display("MISMATCH at %0t: view %0d got %h expected %h",
                         $time, n.sel, obs(n.sel), n.exp);
            end
        end
    end

    // ****************************************************************
    // Driver tasks
    // ****************************************************************
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    task automatic note(input int d, input int s, input logic [7:0] e,
                        input logic [7:0] m = 8'hFF);
        notes.push_back('{cyc + d, s, e, m});
    endtask : note

    task automatic tick(input int k = 1);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'h1;
        tick();
        regWrEn = 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        regAddr = a;
        note(1, 0, e);
        tick();
    endtask : rd

    task automatic do_reset(input logic ds, input logic ss);
        rst = 1'h1;
        directClockStrapPin = ds;
        standbyPin = ss;
        tick(5);
        rst = 1'h0;
        note(0, 1, `CCA_RCR_RST | {2'h0, ds, 5'h00});
        note(0, 2, `CCA_MCR_RST | {ss, 7'h00}, 8'hCF);
        rd(`CCA_ADDR_RCR, `CCA_RCR_RST | {2'h0, ds, 5'h00});
        rd(`CCA_ADDR_MCR, `CCA_MCR_RST | {ss, 7'h00});
        rd(`CCA_ADDR_ACR, `CCA_ACR_RST);
    endtask : do_reset

    // Tail notes are skipped when a later write cuts the period short
    task automatic hf(input int d, input int w, input bit full);
        int h;
        h = (d == 0) ? 32 : d;
        wr(`CCA_ADDR_ACR, {3'h1, 5'(d)});
        note(1, 3, 8'h00);
        note(4 * h, 3, 8'h00);
        note(4 * h + 1, 3, 8'h01);
        if (full) begin
            note(8 * h, 3, 8'h01);
            note(8 * h + 1, 3, 8'h00);
        end
        tick(w);
    endtask : hf

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        logic [7:0] r;
        logic [7:0] m;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'h0;
        vcoPulse = 1'h1;
        void'($urandom(32'h40aa461b));
        do_reset(1'h0, 1'h0);
        wr(`CCA_ADDR_ID, ~TB_ID);
        rd(`CCA_ADDR_ID, TB_ID);
        wr(8'h04, 8'h00);
        rd(8'h04, 8'h00);
        rd(8'h4E, 8'h00);
        repeat (8) begin
            r = 8'($urandom);
            m = (8'($urandom) & 8'hCF) | 8'h30;
            wr(`CCA_ADDR_RCR, r);
            note(0, 1, r);
            rd(`CCA_ADDR_RCR, r);
            wr(`CCA_ADDR_MCR, m);
            note(0, 2, m, 8'hCF);
            rd(`CCA_ADDR_MCR, m);
        end
        wr(`CCA_ADDR_MCR, 8'h34);
        tick();
        for (int b = 0; b < 2; b++) begin
            wr(`CCA_ADDR_ACR, {3'h0, 4'($urandom), 1'(b)});
            note(1, 3, 8'(b));
            note(9, 3, 8'(b));
            tick(10);
        end
        for (int i = 1; i <= 4; i++) hf(i % 4, 8 * 32 + 2, 1'h1);
        hf(2, 10, 1'h0);
        hf(1, 10, 1'h1);
        hf(1, 5, 1'h0);
        wr(`CCA_ADDR_MCR, 8'h74);
        note(0, 2, 8'h74, 8'hCF);
        note(4, 3, 8'h01);
        note(8, 3, 8'h01);
        tick(9);
        wr(`CCA_ADDR_MCR, 8'h34);
        tick();
        for (int c = 2; c < 8; c++) begin
            wr(`CCA_ADDR_ACR, {3'(c), 5'($urandom)});
            note(1, 3, 8'h00);
            note(200, 3, 8'h00);
            // Irregular VCO pulses; the LF half period is far longer
            repeat (201) begin
                vcoPulse = 1'($urandom);
                tick();
            end
        end
        do_reset(1'h1, 1'h1);
        for (int i = 0; i < 400 && notes.size() > 0; i++) tick();
        if (notes.size() > 0) mismatches++;
        conclude();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        conclude();
    end
endmodule : tb_top
